// ===== verilog/tec_pkg.sv
// constants for the timer event and interrupt control slice
`default_nettype none
package tec_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_BV_CLR  = 8'h06;
	localparam logic [7:0] IDX_BV_SET  = 8'h07;
	localparam logic [7:0] IDX_EV_CTRL = 8'h09;
	localparam logic [7:0] IDX_INT_EN  = 8'h0a;
	localparam logic [7:0] IDX_INT_FLG = 8'h0b;
	localparam logic [7:0] IDX_DBG     = 8'h0e;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] RST_BV   = 4'h0;
	localparam logic [2:0] RST_CMP_FLG = 3'h0;
	localparam logic [15:0] RST_CMP = 16'h0000;
	// field positions
	localparam int BV_PER      = 0;
	localparam int BV_CMP0     = 1;
	localparam int EV_A_EN     = 0;
	localparam int EV_A_ACT_LO = 1;
	localparam int EV_B_EN     = 4;
	localparam int EV_B_ACT_LO = 5;
	localparam int INT_OVF     = 0;
	localparam int INT_CMP0    = 4;
	localparam int DBG_RUN     = 0;
	// action codes, input A
	localparam logic [2:0] ACT_A_RISE  = 3'h0;
	localparam logic [2:0] ACT_A_BOTH  = 3'h1;
	localparam logic [2:0] ACT_A_HIGH  = 3'h2;
	localparam logic [2:0] ACT_A_UPDN  = 3'h3;
	// action codes, input B
	localparam logic [2:0] ACT_B_UPDN  = 3'h3;
	localparam logic [2:0] ACT_B_RST_RISE = 3'h4;
	localparam logic [2:0] ACT_B_RST_BOTH = 3'h5;
	localparam logic [2:0] ACT_B_RST_HIGH = 3'h6;
endpackage
`default_nettype wire

// ===== verilog/tec_timer_event_irq_control.sv
// event, buffer-valid and interrupt control slice of a 16-bit timer
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - writing a compare buffer sets that channel's buffer-valid flag
// - an update condition clears all compare buffer-valid flags
// - period buffer write sets period flag; update clears it
// - set register: ones set flags, zeros leave them alone
// - input A ignored when disabled, else action A applies
// - input B ignored when disabled, else action B applies
// - action A: rising edges, both edges, or clocks while high
// - action A event_direction_control: clocks counted, low up, high down
// - action B event_direction_control: B sets direction, A selects quantity
// - action B restart on rising, either edge, or while high
// - compare interrupt enables at bits 6, 5, 4
// - overflow interrupt enable at bit 0
// - compare match sets the channel's interrupt flag
// - compare flags clear only by writing one
// - overflow flag set at top or bottom per waveform mode
// - overflow flag clears only by writing one
// - run-in-debug zero: halt and ignore events in break
// - run-in-debug one: run normally in break
// - clear register: ones clear flags, zeros leave them alone
// - update loads each compare register from its buffer
module tec_timer_event_irq_control (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        event_a_i,
	input  wire logic        event_b_i,
	input  wire logic        debug_break_i,
	input  wire logic        update_i,
	input  wire logic        top_i,
	input  wire logic        bottom_i,
	input  wire logic        ovf_at_top_i,
	input  wire logic        ovf_at_bottom_i,
	input  wire logic [2:0]  compare_match_i,
	input  wire logic        period_buffer_write_i,
	input  wire logic [2:0]  compare_buffer_write_i,
	input  wire logic [47:0] compare_buffer_i,
	input  wire logic        prescale_tick_i,
	output logic      [47:0] compare_register_o,
	output logic             count_step_o,
	output logic             count_down_o,
	output logic             restart_o,
	output logic             halt_o,
	output logic             ovf_irq_o,
	output logic      [2:0]  compare_irq_o,
	output logic      [3:0]  buffer_valid_o
);

	logic [3:0] buffer_valid_r;
	logic [7:0] event_control_r;
	logic [7:0] interrupt_enable_r;
	logic       ovf_flag_r;
	logic [2:0] cmp_flag_r;
	logic       run_in_debug_r;
	logic [1:0] ev_a_sync_r;
	logic [1:0] ev_b_sync_r;
	logic [1:0] brk_sync_r;
	logic       ev_a_prev_r;
	logic       ev_b_prev_r;

	logic       req;
	logic       wr;
	logic [7:0] wbyte;
	logic       hit;
	logic       running;
	logic       ev_a;
	logic       ev_b;
	logic       a_rise;
	logic       a_any;
	logic       b_rise;
	logic       b_any;
	logic       a_en;
	logic       b_en;
	logic [2:0] act_a;
	logic [2:0] act_b;
	logic       step_nxt;
	logic       down_nxt;
	logic       restart_nxt;
	logic [7:0] rdata;
	logic [3:0] buffer_valid_nxt;
	logic       ovf_set;
	logic       bv_clr_w;
	logic       bv_set_w;
	logic       ev_ctrl_w;
	logic       int_en_w;
	logic       flg_clr_w;
	logic       dbg_w;

	// bus access, low lane carries the byte
	assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr    = req && wb_we_i && wb_sel_i[0];
	assign wbyte = wb_dat_i[7:0];

	// register write strobes
	assign bv_clr_w  = wr && wb_adr_i == tec_pkg::IDX_BV_CLR;
	assign bv_set_w  = wr && wb_adr_i == tec_pkg::IDX_BV_SET;
	assign ev_ctrl_w = wr && wb_adr_i == tec_pkg::IDX_EV_CTRL;
	assign int_en_w  = wr && wb_adr_i == tec_pkg::IDX_INT_EN;
	assign flg_clr_w = wr && wb_adr_i == tec_pkg::IDX_INT_FLG;
	assign dbg_w     = wr && wb_adr_i == tec_pkg::IDX_DBG;

	// pin inputs through two flops
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ev_a_sync_r <= 2'h0;
			ev_b_sync_r <= 2'h0;
			brk_sync_r  <= 2'h0;
		end
		else
		begin
			ev_a_sync_r <= {ev_a_sync_r[0], event_a_i};
			ev_b_sync_r <= {ev_b_sync_r[0], event_b_i};
			brk_sync_r  <= {brk_sync_r[0], debug_break_i};
		end
	end

	assign ev_a = ev_a_sync_r[1];
	assign ev_b = ev_b_sync_r[1];
	assign running = run_in_debug_r || !brk_sync_r[1];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ev_a_prev_r <= 1'b0;
			ev_b_prev_r <= 1'b0;
		end
		else
		begin
			ev_a_prev_r <= ev_a;
			ev_b_prev_r <= ev_b;
		end
	end

	assign a_rise = ev_a && !ev_a_prev_r;
	assign a_any  = ev_a != ev_a_prev_r;
	assign b_rise = ev_b && !ev_b_prev_r;
	assign b_any  = ev_b != ev_b_prev_r;
	assign act_a  = event_control_r[tec_pkg::EV_A_ACT_LO +: 3];
	assign act_b  = event_control_r[tec_pkg::EV_B_ACT_LO +: 3];
	assign a_en   = event_control_r[tec_pkg::EV_A_EN] && running;
	assign b_en   = event_control_r[tec_pkg::EV_B_EN] && running;

	// event actions
	always_comb
	begin
		step_nxt    = 1'b0;
		down_nxt    = count_down_o;
		restart_nxt = 1'b0;
		if (a_en)
		begin
			case (act_a)
				tec_pkg::ACT_A_RISE: step_nxt = a_rise;
				tec_pkg::ACT_A_BOTH: step_nxt = a_any;
				tec_pkg::ACT_A_HIGH: step_nxt = prescale_tick_i && ev_a;
				tec_pkg::ACT_A_UPDN:
				begin
					step_nxt = prescale_tick_i;
					if (prescale_tick_i)
						down_nxt = ev_a;
				end
				default: step_nxt = 1'b0;
			endcase
		end
		else if (running)
			step_nxt = prescale_tick_i;
		if (b_en)
		begin
			case (act_b)
				tec_pkg::ACT_B_UPDN:
				begin
					if (step_nxt)
						down_nxt = ev_b;
				end
				tec_pkg::ACT_B_RST_RISE: restart_nxt = b_rise;
				tec_pkg::ACT_B_RST_BOTH: restart_nxt = b_any;
				tec_pkg::ACT_B_RST_HIGH: restart_nxt = ev_b;
				default: restart_nxt = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			count_step_o <= 1'b0;
			count_down_o <= 1'b0;
			restart_o    <= 1'b0;
		end
		else
		begin
			count_step_o <= step_nxt;
			count_down_o <= down_nxt;
			restart_o    <= restart_nxt;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			halt_o <= 1'b0;
		else
			halt_o <= !running;
	end

	// buffer-valid flags; hardware set wins over clears
	always_comb
	begin
		buffer_valid_nxt = buffer_valid_r;
		if (update_i)
			buffer_valid_nxt = tec_pkg::RST_BV;
		if (bv_clr_w)
			buffer_valid_nxt = buffer_valid_nxt & ~wbyte[3:0];
		if (bv_set_w)
			buffer_valid_nxt = buffer_valid_nxt | wbyte[3:0];
		buffer_valid_nxt[tec_pkg::BV_PER] =
			buffer_valid_nxt[tec_pkg::BV_PER]
			| period_buffer_write_i;
		buffer_valid_nxt[tec_pkg::BV_CMP0 +: 3] =
			buffer_valid_nxt[tec_pkg::BV_CMP0 +: 3]
			| compare_buffer_write_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			buffer_valid_r <= tec_pkg::RST_BV;
		else
			buffer_valid_r <= buffer_valid_nxt;
	end

	// software control registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			event_control_r <= tec_pkg::RST_BYTE;
		else if (ev_ctrl_w)
			event_control_r <= wbyte;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			interrupt_enable_r <= tec_pkg::RST_BYTE;
		else if (int_en_w)
			interrupt_enable_r <= {1'b0, wbyte[6:4], 3'h0,
				wbyte[tec_pkg::INT_OVF]};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			run_in_debug_r <= 1'b0;
		else if (dbg_w)
			run_in_debug_r <= wbyte[tec_pkg::DBG_RUN];
	end

	// overflow flag and request, set beats write-one-to-clear
	assign ovf_set = running && ((top_i && ovf_at_top_i)
		|| (bottom_i && ovf_at_bottom_i));

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ovf_flag_r <= 1'b0;
		else
			ovf_flag_r <= ovf_set || (ovf_flag_r
				&& !(flg_clr_w && wbyte[tec_pkg::INT_OVF]));
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ovf_irq_o <= 1'b0;
		else
			ovf_irq_o <= ovf_flag_r
				&& interrupt_enable_r[tec_pkg::INT_OVF];
	end

	// per compare channel: register load, flag and request
	generate
		for (genvar ch = 0; ch < 3; ch++)
		begin : g_cmp
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					compare_register_o[16*ch +: 16] <= tec_pkg::RST_CMP;
				else if (update_i)
					compare_register_o[16*ch +: 16]
						<= compare_buffer_i[16*ch +: 16];
			end

			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					cmp_flag_r[ch] <= tec_pkg::RST_CMP_FLG[ch];
				else
					cmp_flag_r[ch] <= (running && compare_match_i[ch])
						|| (cmp_flag_r[ch] && !(flg_clr_w
						&& wbyte[tec_pkg::INT_CMP0 + ch]));
			end

			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					compare_irq_o[ch] <= 1'b0;
				else
					compare_irq_o[ch] <= cmp_flag_r[ch]
						&& interrupt_enable_r[tec_pkg::INT_CMP0 + ch];
			end
		end
	endgenerate

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			buffer_valid_o <= tec_pkg::RST_BV;
		else
			buffer_valid_o <= buffer_valid_r;
	end

	// read mux
	always_comb
	begin
		hit   = 1'b1;
		rdata = 8'h00;
		case (wb_adr_i)
			tec_pkg::IDX_BV_CLR:  rdata = {4'h0, buffer_valid_r};
			tec_pkg::IDX_BV_SET:  rdata = {4'h0, buffer_valid_r};
			tec_pkg::IDX_EV_CTRL: rdata = event_control_r;
			tec_pkg::IDX_INT_EN:  rdata = interrupt_enable_r;
			tec_pkg::IDX_INT_FLG: rdata = {1'b0, cmp_flag_r, 3'h0, ovf_flag_r};
			tec_pkg::IDX_DBG:     rdata = {7'h00, run_in_debug_r};
			default:              hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= req;
			wb_dat_o <= (req && !wb_we_i && hit) ? {24'h000000, rdata} : 32'h00000000;
		end
	end

endmodule
`default_nettype wire

// ===== dv/tec_event_net.sv
// event network model: event lines delayed by a chosen latency
`timescale 1ns/1ns
`default_nettype none
module tec_event_net (
	input  wire logic       clk_i,
	input  wire logic [1:0] req_i,
	input  wire logic [3:0] delay_i,
	output logic      [1:0] event_o
);
	logic [15:0] a_r = 16'h0;
	logic [15:0] b_r = 16'h0;
	always @(posedge clk_i)
	begin
		a_r <= {a_r[14:0], req_i[0]};
		b_r <= {b_r[14:0], req_i[1]};
	end
	assign event_o = {b_r[delay_i], a_r[delay_i]};
endmodule
`default_nettype wire

// ===== dv/tec_checker.sv
// assertions on the timer control slice ports
`timescale 1ns/1ns
`default_nettype none
module tec_checker (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_ack_o,
	input wire logic        update_i,
	input wire logic        debug_break_i,
	input wire logic        halt_o,
	input wire logic        count_step_o,
	input wire logic        restart_o,
	input wire logic        ovf_irq_o,
	input wire logic [2:0]  compare_irq_o,
	input wire logic        period_buffer_write_i,
	input wire logic [2:0]  compare_buffer_write_i,
	input wire logic [47:0] compare_buffer_i,
	input wire logic [47:0] compare_register_o,
	input wire logic [3:0]  buffer_valid_o
);
	wire logic [3:0] irq = {ovf_irq_o, compare_irq_o};
	wire logic       bw = period_buffer_write_i | (|compare_buffer_write_i);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_answer_a: assert property (wb_cyc_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack long");
	cmp_load_a: assert property (
		update_i && !halt_o |=> compare_register_o == $past(compare_buffer_i))
		else $error("compare not loaded");
	cmp_hold_a: assert property (
		!update_i |=> $stable(compare_register_o))
		else $error("compare changed");
	bv_period_a: assert property (
		period_buffer_write_i |-> ##[1:2] buffer_valid_o[0])
		else $error("period valid not set");
	bv_compare_a: assert property (
		compare_buffer_write_i[1] |-> ##[1:2] buffer_valid_o[2])
		else $error("compare valid not set");
	bv_clear_a: assert property (
		update_i && !halt_o && !bw ##1 !bw |-> ##[0:1] buffer_valid_o == 4'h0)
		else $error("valid not cleared");
	irq_hold_a: assert property (
		!wb_cyc_i |=> ($past(irq) & ~irq) == 4'h0)
		else $error("flag cleared itself");
	halt_still_a: assert property (
		halt_o |-> !count_step_o && !restart_o)
		else $error("count while halted");
	halt_free_a: assert property (
		!debug_break_i [*5] |-> !halt_o)
		else $error("halt without break");
endmodule
bind tec_timer_event_irq_control tec_checker i_tec_checker (.*);
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the timer control slice
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0, debug_break_i = 1'b0, update_i = 1'b0;
	logic        top_i = 1'b0, bottom_i = 1'b0, prescale_tick_i = 1'b0;
	logic        ovf_at_top_i = 1'b0, ovf_at_bottom_i = 1'b0;
	logic        period_buffer_write_i = 1'b0, wb_ack_o, count_step_o;
	logic        count_down_o, restart_o, halt_o, ovf_irq_o;
	logic [1:0]  req = 2'h0;
	logic [2:0]  compare_match_i = 3'h0, compare_buffer_write_i = 3'h0;
	logic [2:0]  compare_irq_o;
	logic [3:0]  wb_sel_i = 4'h0, delay = 4'h0, buffer_valid_o;
	logic [7:0]  wb_adr_i = 8'h00, d, exp_q[$];
	logic [7:0]  regs[7] = '{8'h06, 8'h07, 8'h09, 8'h0a, 8'h0b, 8'h0e, 8'h20};
	// control, tick, break, run, steps [9:5], restarts [4:0]
	logic [23:0] row[11] = '{24'h010060, 24'h0300c0, 24'h058180, 24'h090000,
		24'h900003, 24'hb00006, 24'hd0000c, 24'h300000, 24'h8e0000,
		24'h014000, 24'h016060};
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic [47:0] compare_buffer_i = 48'h0, compare_register_o;
	wire logic   event_a_i, event_b_i;
	int          num_errors = 0, samples_checked = 0, steps = 0, rsts = 0;
	int          seed = 72601;
	int          base_s = 0, base_r = 0;
	tec_timer_event_irq_control i_tec_timer_event_irq_control (.*);
	tec_event_net i_tec_event_net (.clk_i, .req_i(req), .delay_i(delay),
		.event_o({event_b_i, event_a_i}));
	always #5 clk_i = ~clk_i;
	task automatic chk(input string n, input logic [47:0] seen, exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, v);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, w, 4'hf};
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, v};
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1)
			@(posedge clk_i);
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, e);
		exp_q.push_back(e);
		bus(1'b0, a, 8'h00);
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		steps <= steps + (count_step_o === 1'b1);
		rsts <= rsts + (restart_o === 1'b1);
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			chk("read", wb_dat_o, {24'h0, exp_q.pop_front()});
	end
	initial
	begin
		#50000;
		num_errors++;
		end_sim();
	end
	initial
	begin
		wait_n(3);
		rst_i <= 1'b0;
		wait_n(1);
		foreach (regs[i])
			rd(regs[i], 8'h00);
		d = 8'($random(seed));
		bus(1'b1, 8'h09, d);
		rd(8'h09, d);
		bus(1'b1, 8'h20, 8'hff);
		rd(8'h20, 8'h00);
		{period_buffer_write_i, compare_buffer_write_i} <= 4'ha;
		wait_n(1);
		{period_buffer_write_i, compare_buffer_write_i} <= 4'h0;
		rd(8'h07, 8'h05);
		bus(1'b1, 8'h06, 8'h04);
		rd(8'h06, 8'h01);
		bus(1'b1, 8'h07, 8'h0a);
		rd(8'h07, 8'h0b);
		compare_buffer_i <= {$random(seed), 16'($random(seed))};
		update_i <= 1'b1;
		wait_n(1);
		update_i <= 1'b0;
		wait_n(2);
		chk("compare", compare_register_o, compare_buffer_i);
		rd(8'h07, 8'h00);
		bus(1'b1, 8'h0a, 8'hff);
		rd(8'h0a, 8'h71);
		{ovf_at_top_i, compare_match_i, top_i} <= 5'h1f;
		wait_n(1);
		{compare_match_i, top_i} <= 4'h0;
		rd(8'h0b, 8'h71);
		chk("irq", {ovf_irq_o, compare_irq_o}, 4'hf);
		bus(1'b1, 8'h0b, 8'h10);
		rd(8'h0b, 8'h61);
		bus(1'b1, 8'h0a, 8'h00);
		chk("irq", {ovf_irq_o, compare_irq_o}, 4'h0);
		bus(1'b1, 8'h0b, 8'hff);
		{ovf_at_top_i, ovf_at_bottom_i, top_i} <= 3'h3;
		wait_n(1);
		{top_i, bottom_i} <= 2'h1;
		wait_n(1);
		bottom_i <= 1'b0;
		rd(8'h0b, 8'h01);
		foreach (row[i])
		begin
			bus(1'b1, 8'h0e, {7'h0, row[i][13]});
			{prescale_tick_i, debug_break_i} <= row[i][15:14];
			delay <= 4'($random(seed));
			bus(1'b1, 8'h09, row[i][23:16]);
			wait_n(6);
			base_s = steps;
			base_r = rsts;
			repeat (3)
			begin
				req <= 2'h3;
				wait_n(4);
				req <= 2'h0;
				wait_n(4);
			end
			wait_n(24);
			prescale_tick_i <= 1'b0;
			wait_n(3);
			chk("steps", steps - base_s, row[i][9:5]);
			chk("restarts", rsts - base_r, row[i][4:0]);
			chk("halt", halt_o, row[i][14] & ~row[i][13]);
		end
		{prescale_tick_i, debug_break_i} <= 2'h2;
		for (int i = 0; i < 2; i++)
		begin
			bus(1'b1, 8'h09, i ? 8'h70 : 8'h07);
			req <= 2'h3;
			wait_n(24);
			chk("down", count_down_o, 1'b1);
			req <= 2'h0;
			wait_n(24);
			chk("down", count_down_o, 1'b0);
		end
		end_sim();
	end
endmodule
`default_nettype wire
